// file: logic/gtc_pkg.sv
// constants for the gated 16-bit timer/counter
`default_nettype none
package gtc_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_TIMER_CONTROL = 12'hfcd;
   localparam logic [11:0] IDX_COUNT_LOW = 12'hfce;
   localparam logic [11:0] IDX_COUNT_HIGH = 12'hfcf;
   localparam logic [11:0] IDX_GATE_CONTROL = 12'hfd0;
   localparam logic [11:0] IDX_STATUS = 12'hfd1;
   localparam int BYTE_SHIFT = 2;
   // timer_control fields
   localparam int TC_RUN_ENABLE = 0;
   localparam int TC_WIDE_ACCESS = 1;
   localparam int TC_EXT_SYNC_DIS = 2;
   localparam int TC_LP_OSC_EN = 3;
   localparam int TC_PRESCALE_LO = 4;
   localparam int TC_CLK_SRC_LO = 6;
   localparam logic [7:0] TC_RESET = 8'h00;
   // clock source codes
   localparam logic [1:0] SRC_INSTR = 2'h0;
   localparam logic [1:0] SRC_SYSTEM = 2'h1;
   localparam logic [1:0] SRC_EXTERNAL = 2'h2;
   // prescale codes
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV2 = 2'h1;
   localparam logic [1:0] PS_DIV4 = 2'h2;
   localparam logic [1:0] PS_DIV8 = 2'h3;
   // gate_control fields
   localparam int GC_LEVEL_STATUS = 2;
   localparam int GC_GO_DONE = 3;
   localparam int GC_SINGLE_PULSE = 4;
   localparam int GC_TOGGLE = 5;
   localparam int GC_POLARITY = 6;
   localparam int GC_GATE_ENABLE = 7;
   localparam logic [7:0] GC_WR_MASK = 8'hf8;
   localparam logic [7:0] GC_RESET = 8'h00;
   // status fields
   localparam int ST_OVERFLOW = 0;
   // instruction clock is the system clock divided by four
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum {SEL_NONE, SEL_TC, SEL_LOW, SEL_HIGH, SEL_GC, SEL_ST} gtc_sel_t;
endpackage : gtc_pkg
`default_nettype wire

// file: logic/gtc_prescaler.sv
// input prescaler: passes every 1st, 2nd, 4th or 8th input tick
`default_nettype none
module gtc_prescaler
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [1:0] sel,
   output logic tick_out
);
   logic [2:0] cnt_r;
   logic [2:0] last;

   always_comb
   begin
      case (sel)
         gtc_pkg::PS_DIV1: last = 3'h0;
         gtc_pkg::PS_DIV2: last = 3'h1;
         gtc_pkg::PS_DIV4: last = 3'h3;
         gtc_pkg::PS_DIV8: last = 3'h7;
         default: last = 3'h0;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst || clear)
         cnt_r <= 3'h0;
      else if (tick_in)
         cnt_r <= (cnt_r >= last) ? 3'h0 : cnt_r + 3'h1;
   end

   assign tick_out = tick_in && (cnt_r >= last);
endmodule : gtc_prescaler
`default_nettype wire

// file: logic/gtc_timer.sv
// gated 16-bit timer/counter with an AXI4-Lite register slave
// What this block does
// - 16-bit counter held in two byte registers; overflow raises a request.
// - counter advances only while run_enable (timer_control bit 0) is one.
// - source code 10 external, 01 system clock, otherwise instruction clock.
// - prescaler divides by 1, 2, 4 or 8 for codes 00 to 11.
// - external source uses lp oscillator when lp_osc_enable set, else the pin.
// - oscillator powered when either timer's oscillator enable is one.
// - ext_sync_disable one uses external input raw, zero synchronises it.
// - wide_access_enable selects one 16-bit buffered access or two byte accesses.
// - special event trigger clears the counter.
// - set single_pulse_enable, then gate_go_done; counting starts at next increment.
// - go_done clears at gate trailing edge; further gate events ignored until re-set.
// - clearing single_pulse_enable also clears gate_go_done.
// - toggle plus single pulse counts over one full gate source cycle.
// - gate_level_status always shows the current gate level.
`default_nettype none
module gtc_timer
#(
   parameter int ADDR_W = 16
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_clock_pin,
   input wire logic lp_oscillator,
   input wire logic companion_lp_osc_enable,
   input wire logic gate_in,
   input wire logic special_event,
   output logic lp_osc_power,
   output logic overflow_request
);
   logic [7:0] tc_r;
   logic [7:0] gc_r;
   logic [15:0] count_r;
   logic [7:0] high_buf_r;
   logic ovf_r;
   logic aw_rdy_r;
   logic w_rdy_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic ar_rdy_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [1:0] instr_cnt_r;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_prev_r;
   logic gate_lvl_r;
   logic gate_prev_r;
   logic toggle_r;
   logic eff_prev_r;
   logic pulse_seen_r;
   logic lp_pwr_r;

   function automatic gtc_pkg::gtc_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] idx;
      idx = addr >> gtc_pkg::BYTE_SHIFT;
      if (addr[1:0] != 2'h0)
         return gtc_pkg::SEL_NONE;
      else if (idx == ADDR_W'(gtc_pkg::IDX_TIMER_CONTROL))
         return gtc_pkg::SEL_TC;
      else if (idx == ADDR_W'(gtc_pkg::IDX_COUNT_LOW))
         return gtc_pkg::SEL_LOW;
      else if (idx == ADDR_W'(gtc_pkg::IDX_COUNT_HIGH))
         return gtc_pkg::SEL_HIGH;
      else if (idx == ADDR_W'(gtc_pkg::IDX_GATE_CONTROL))
         return gtc_pkg::SEL_GC;
      else if (idx == ADDR_W'(gtc_pkg::IDX_STATUS))
         return gtc_pkg::SEL_ST;
      else
         return gtc_pkg::SEL_NONE;
   endfunction : decode

   // control fields
   logic run_enable;
   logic wide_access_enable;
   logic ext_sync_disable;
   logic lp_osc_enable;
   logic [1:0] prescale_select;
   logic [1:0] clock_source_select;
   logic gate_enable;
   logic gate_polarity;
   logic toggle_mode;
   logic single_pulse_enable;
   logic gate_go_done;

   assign run_enable = tc_r[gtc_pkg::TC_RUN_ENABLE];
   assign wide_access_enable = tc_r[gtc_pkg::TC_WIDE_ACCESS];
   assign ext_sync_disable = tc_r[gtc_pkg::TC_EXT_SYNC_DIS];
   assign lp_osc_enable = tc_r[gtc_pkg::TC_LP_OSC_EN];
   assign prescale_select = tc_r[gtc_pkg::TC_PRESCALE_LO +: 2];
   assign clock_source_select = tc_r[gtc_pkg::TC_CLK_SRC_LO +: 2];
   assign gate_enable = gc_r[gtc_pkg::GC_GATE_ENABLE];
   assign gate_polarity = gc_r[gtc_pkg::GC_POLARITY];
   assign toggle_mode = gc_r[gtc_pkg::GC_TOGGLE];
   assign single_pulse_enable = gc_r[gtc_pkg::GC_SINGLE_PULSE];
   assign gate_go_done = gc_r[gtc_pkg::GC_GO_DONE];

   // write channel
   logic wr_do;
   gtc_pkg::gtc_sel_t wr_sel;
   assign wr_do = !aw_rdy_r && !w_rdy_r && !bvalid_r;
   assign wr_sel = wlane_r ? decode(awaddr_r) : gtc_pkg::SEL_NONE;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         aw_rdy_r <= 1'b1;
         w_rdy_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= gtc_pkg::RESP_OKAY;
         awaddr_r <= '0;
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && aw_rdy_r)
         begin
            aw_rdy_r <= 1'b0;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && w_rdy_r)
         begin
            w_rdy_r <= 1'b0;
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
         end
         if (wr_do)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (decode(awaddr_r) == gtc_pkg::SEL_NONE) ? gtc_pkg::RESP_SLVERR : gtc_pkg::RESP_OKAY;
         end
         if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
            aw_rdy_r <= 1'b1;
            w_rdy_r <= 1'b1;
         end
      end
   end

   // read channel
   logic rd_do;
   gtc_pkg::gtc_sel_t rd_sel;
   logic [7:0] rd_byte;
   assign rd_do = s_axi_arvalid && ar_rdy_r;
   assign rd_sel = decode(s_axi_araddr);

   always_comb
   begin
      rd_byte = 8'h00;
      case (rd_sel)
         gtc_pkg::SEL_TC: rd_byte = tc_r;
         gtc_pkg::SEL_LOW: rd_byte = count_r[7:0];
         gtc_pkg::SEL_HIGH: rd_byte = wide_access_enable ? high_buf_r : count_r[15:8];
         gtc_pkg::SEL_GC: rd_byte = {gc_r[7:3], gate_lvl_r, 2'h0};
         gtc_pkg::SEL_ST: rd_byte = {7'h00, ovf_r};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ar_rdy_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= gtc_pkg::RESP_OKAY;
      end
      else if (rd_do)
      begin
         ar_rdy_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rd_byte};
         rresp_r <= (rd_sel == gtc_pkg::SEL_NONE) ? gtc_pkg::RESP_SLVERR : gtc_pkg::RESP_OKAY;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_r <= 1'b0;
         ar_rdy_r <= 1'b1;
      end
   end

   // timer_control register
   always_ff @(posedge clock)
   begin
      if (rst)
         tc_r <= gtc_pkg::TC_RESET;
      else if (wr_do && wr_sel == gtc_pkg::SEL_TC)
         tc_r <= wbyte_r;
   end

   // oscillator driver power: or of both timers' enables
   always_ff @(posedge clock)
   begin
      if (rst)
         lp_pwr_r <= 1'b0;
      else
         lp_pwr_r <= lp_osc_enable || companion_lp_osc_enable;
   end

   // input clock selection
   logic ext_src;
   logic ext_in;
   logic ext_tick;
   logic instr_tick;
   logic src_tick;

   assign ext_src = lp_osc_enable ? lp_oscillator : ext_clock_pin;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_prev_r <= 1'b0;
         instr_cnt_r <= 2'h0;
      end
      else
      begin
         ext_s1_r <= ext_src;
         ext_s2_r <= ext_s1_r;
         ext_prev_r <= ext_in;
         instr_cnt_r <= instr_cnt_r + 2'h1;
      end
   end

   // raw mode skips two cycles of latency but sees any pin glitch
   assign ext_in = ext_sync_disable ? ext_src : ext_s2_r;
   assign ext_tick = ext_in && !ext_prev_r;
   assign instr_tick = (instr_cnt_r == gtc_pkg::INSTR_DIV_LAST);

   always_comb
   begin
      case (clock_source_select)
         gtc_pkg::SRC_EXTERNAL: src_tick = ext_tick;
         gtc_pkg::SRC_SYSTEM: src_tick = 1'b1;
         default: src_tick = instr_tick;
      endcase
   end

   logic count_wr;
   logic pre_tick;
   assign count_wr = wr_do && (wr_sel == gtc_pkg::SEL_LOW || wr_sel == gtc_pkg::SEL_HIGH);

   gtc_prescaler u_prescaler
   (
      .clock(clock),
      .rst(rst),
      .clear(count_wr),
      .tick_in(src_tick && run_enable),
      .sel(prescale_select),
      .tick_out(pre_tick)
   );

   // gate logic
   logic gate_lvl;
   logic gate_eff;
   logic gate_rise;
   logic eff_fall;
   logic gate_ok;
   logic inc;

   assign gate_lvl = gate_in ^ gate_polarity;
   assign gate_rise = gate_lvl_r && !gate_prev_r;
   assign gate_eff = toggle_mode ? toggle_r : gate_lvl_r;
   assign eff_fall = !gate_eff && eff_prev_r;
   assign gate_ok = !gate_enable || (gate_eff && (!single_pulse_enable || gate_go_done));
   assign inc = pre_tick && run_enable && gate_ok;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         gate_lvl_r <= 1'b0;
         gate_prev_r <= 1'b0;
         toggle_r <= 1'b0;
         eff_prev_r <= 1'b0;
      end
      else
      begin
         gate_lvl_r <= gate_lvl;
         gate_prev_r <= gate_lvl_r;
         eff_prev_r <= gate_eff;
         if (!gate_enable || !toggle_mode)
            toggle_r <= 1'b0;
         else if (gate_rise)
            toggle_r <= !toggle_r;
      end
   end

   // gate_control register with hardware-cleared go_done
   logic [7:0] gc_wr;
   assign gc_wr = wbyte_r & gtc_pkg::GC_WR_MASK;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         gc_r <= gtc_pkg::GC_RESET;
         pulse_seen_r <= 1'b0;
      end
      else
      begin
         if (wr_do && wr_sel == gtc_pkg::SEL_GC)
         begin
            gc_r <= gc_wr;
            if (!gc_wr[gtc_pkg::GC_SINGLE_PULSE])
               gc_r[gtc_pkg::GC_GO_DONE] <= 1'b0;
            pulse_seen_r <= 1'b0;
         end
         else if (single_pulse_enable && gate_go_done)
         begin
            if (gate_eff && inc)
               pulse_seen_r <= 1'b1;
            if (pulse_seen_r && eff_fall)
            begin
               gc_r[gtc_pkg::GC_GO_DONE] <= 1'b0;
               pulse_seen_r <= 1'b0;
            end
         end
      end
   end

   // counter and high buffer
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         count_r <= 16'h0000;
         high_buf_r <= 8'h00;
      end
      else
      begin
         if (rd_do && rd_sel == gtc_pkg::SEL_LOW && wide_access_enable)
            high_buf_r <= count_r[15:8];
         else if (wr_do && wr_sel == gtc_pkg::SEL_HIGH && wide_access_enable)
            high_buf_r <= wbyte_r;
         if (special_event)
            count_r <= 16'h0000;
         else if (wr_do && wr_sel == gtc_pkg::SEL_LOW)
            count_r <= wide_access_enable ? {high_buf_r, wbyte_r} : {count_r[15:8], wbyte_r};
         else if (wr_do && wr_sel == gtc_pkg::SEL_HIGH && !wide_access_enable)
            count_r <= {wbyte_r, count_r[7:0]};
         else if (inc)
            count_r <= count_r + 16'h0001;
      end
   end

   // rollover sets the flag; a set wins over a same-cycle write-one clear
   always_ff @(posedge clock)
   begin
      if (rst)
         ovf_r <= 1'b0;
      else if (inc && !special_event && !count_wr && count_r == 16'hffff)
         ovf_r <= 1'b1;
      else if (wr_do && wr_sel == gtc_pkg::SEL_ST && wbyte_r[gtc_pkg::ST_OVERFLOW])
         ovf_r <= 1'b0;
   end

   assign s_axi_awready = aw_rdy_r;
   assign s_axi_wready = w_rdy_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ar_rdy_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign lp_osc_power = lp_pwr_r;
   assign overflow_request = ovf_r;
endmodule : gtc_timer
`default_nettype wire

// file: tb/gtc_timer_props.sv
// concurrent checks on the timer's bus and oscillator ports
`default_nettype none
module gtc_timer_props
#(
   parameter int ADDR_W = 16
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic companion_lp_osc_enable,
   input wire logic lp_osc_power,
   input wire logic overflow_request
);
   timeunit 1ns;
   timeprecision 100ps;
   logic rd_bad;
   assign rd_bad = s_axi_araddr[1:0] != 2'h0 || (s_axi_araddr >> 2) < gtc_pkg::IDX_TIMER_CONTROL ||
      (s_axi_araddr >> 2) > gtc_pkg::IDX_STATUS;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_write_answer: assert property (aw_w_taken |=> b_answer)
      else $error("write response not two cycles after request");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after request");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken while response pending");
   a_read_refused: assert property (s_axi_arvalid && s_axi_arready && rd_bad |=>
      s_axi_rresp == gtc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_osc_companion: assert property (companion_lp_osc_enable |=> lp_osc_power)
      else $error("companion enable did not power oscillator");
   a_ovf_sticky: assert property ($fell(overflow_request) |-> $past(s_axi_wvalid && s_axi_wready, 2))
      else $error("overflow flag fell without a write");
endmodule : gtc_timer_props
`default_nettype wire

// file: tb/gtc_ext_model.sv
// far side: external count pin and low-power crystal oscillator
`default_nettype none
module gtc_ext_model
(
   input wire logic clock,
   input wire logic lp_osc_power,
   output logic ext_clock_pin,
   output logic lp_oscillator
);
   timeunit 1ns;
   timeprecision 100ps;
   int ph = 0;
   initial ext_clock_pin = 1'b0;
   initial lp_oscillator = 1'b0;
   // crystal swings with period 6 only while its driver is powered, else rests low
   always @(posedge clock)
   begin
      ph <= lp_osc_power ? (ph + 1) % 6 : 0;
      lp_oscillator <= lp_osc_power && ph >= 3;
   end
   task automatic pins(input int n);
      repeat (n)
      begin
         ext_clock_pin <= 1'b1;
         repeat (3) @(posedge clock);
         ext_clock_pin <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask : pins
endmodule : gtc_ext_model
`default_nettype wire

// file: tb/gtc_timer_tb.sv
// self-checking bench for the gated timer/counter
`default_nettype none
module gtc_timer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic companion_lp_osc_enable = 1'b0, gate_in = 1'b0, special_event = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic ext_clock_pin, lp_oscillator, lp_osc_power, overflow_request;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int n_fail = 0, checks = 0, cyc = 0, seed = 32218, t0, w, e, tw;
   always #2 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   gtc_timer #(.ADDR_W(16)) dut (.*);
   gtc_ext_model ext (.*);
   task automatic end_sim;
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol, input string m);
      checks++;
      if ((^seen) === 1'bx || int'(seen) > int'(exp) + tol || int'(seen) + tol < int'(exp))
      begin
         n_fail++;
         $display("MISMATCH %0t %s seen %0h expected %0h", $time, m, seen, exp);
      end
   endtask : check
   // register i counts from timer_control: 0 control, 1 low, 2 high, 3 gate, 4 status
   function automatic logic [15:0] ad(input int i);
      return {2'h0, gtc_pkg::IDX_TIMER_CONTROL + i[11:0], 2'h0};
   endfunction : ad
   task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && n < 50);
      // the register write lands one edge after this handshake, whatever the response stall
      tw = cyc;
      // random stall exercises a held response
      repeat ($random(seed) & 3) @(posedge clock);
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (!s_axi_bvalid && n < 100);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 100)
         check(0, 1, 0, "write timeout");
      if (n >= 100)
         end_sim();
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (!s_axi_arready && n < 50);
      s_axi_arvalid <= 1'b0;
      repeat ($random(seed) & 3) @(posedge clock);
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (!s_axi_rvalid && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100)
         check(0, 1, 0, "read timeout");
      if (n >= 100)
         end_sim();
   endtask : rd
   task automatic wreg(input int i, input logic [7:0] d);
      wr(ad(i), d, rs);
      check(rs, gtc_pkg::RESP_OKAY, 0, "bresp");
   endtask : wreg
   task automatic rchk(input int i, input logic [31:0] exp, input string m);
      rd(ad(i), rv, rs);
      check(rs, gtc_pkg::RESP_OKAY, 0, "rresp");
      check(rv, exp, 0, m);
   endtask : rchk
   task automatic rcount(input int exp, input int tol, input string m);
      logic [31:0] lo;
      rd(ad(1), lo, rs);
      rd(ad(2), rv, rs);
      check({rv[7:0], lo[7:0]}, exp & 32'hffff, tol, m);
   endtask : rcount
   // preload, run n cycles, stop; w spans the two control handshakes,
   // so random response stalls do not skew the expected count
   task automatic run(input logic [7:0] tc, input int n, input logic [15:0] pre);
      wreg(2, pre[15:8]);
      wreg(1, pre[7:0]);
      wreg(0, tc | 8'h01);
      t0 = tw;
      repeat (n) @(posedge clock);
      wreg(0, tc);
      w = tw - t0;
   endtask : run
   task automatic gpulse(input int n);
      gate_in <= 1'b1;
      repeat (n) @(posedge clock);
      gate_in <= 1'b0;
      repeat (n) @(posedge clock);
   endtask : gpulse
   initial
   begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rchk(0, gtc_pkg::TC_RESET, "control reset");
      rchk(3, gtc_pkg::GC_RESET, "gate reset");
      rchk(4, 0, "status reset");
      rd(ad(5), rv, rs);
      check(rs, gtc_pkg::RESP_SLVERR, 0, "unmapped read");
      wr(ad(1) + 16'h2, 8'h55, rs);
      check(rs, gtc_pkg::RESP_SLVERR, 0, "unaligned write");
      s_axi_wstrb <= 4'h0;
      wr(ad(0), 8'hff, rs);
      s_axi_wstrb <= 4'h1;
      check(rs, gtc_pkg::RESP_OKAY, 0, "masked write");
      rchk(0, gtc_pkg::TC_RESET, "masked write ignored");
      // no capture or compare unit uses this timer, so the system clock is allowed
      for (int s = 0; s < 4; s++)
         for (int p = 0; p < 4; p++)
         begin
            run({s[1:0], p[1:0], 4'h0}, 60 + ($random(seed) & 63), 16'h0);
            e = s == 2 ? 0 : s == 1 ? w >> p : w / (4 << p);
            rcount(e, 1, "internal count");
         end
      for (int k = 0; k < 3; k++)
      begin
         fork
            run({gtc_pkg::SRC_EXTERNAL, 1'b0, k == 2, k == 2, k[0], 2'h0}, 150, 16'h0);
            begin
               repeat (30) @(posedge clock);
               ext.pins(8);
            end
         join
         rcount(k == 2 ? w / 12 : 8, 2, "external count");
      end
      check(lp_osc_power, 1, 0, "osc powered");
      wreg(0, 8'h00);
      companion_lp_osc_enable <= 1'b1;
      repeat (3) @(posedge clock);
      check(lp_osc_power, 1, 0, "companion powers osc");
      companion_lp_osc_enable <= 1'b0;
      repeat (3) @(posedge clock);
      check(lp_osc_power, 0, 0, "osc unpowered");
      run(8'h42, 10, 16'h12fe);
      rchk(1, (32'h12fe + w) & 32'hff, "wide low");
      special_event <= 1'b1;
      @(posedge clock);
      special_event <= 1'b0;
      rchk(2, (32'h12fe + w) >> 8, "buffered high");
      wreg(0, 8'h40);
      rcount(0, 0, "event clear");
      run(8'h40, 20, 16'hfff8);
      rcount(32'hfff8 + w, 1, "wrap");
      check(overflow_request, 1, 0, "overflow set");
      wreg(4, 8'h01);
      repeat (2) @(posedge clock);
      check(overflow_request, 0, 0, "overflow clear");
      gate_in <= 1'b1;
      repeat (4) @(posedge clock);
      rchk(3, 32'h04, "gate level");
      gate_in <= 1'b0;
      // inverted polarity: a low pin reads as an active gate level
      wreg(3, 8'h40);
      rchk(3, 32'h44, "inverted gate level");
      for (int g = 0; g < 2; g++)
      begin
         wreg(3, g ? 8'hb0 : 8'h90);
         wreg(3, g ? 8'hb8 : 8'h98);
         fork
            run(8'h40, 180, 16'h0);
            begin
               repeat (30) @(posedge clock);
               repeat (3) gpulse(g ? 10 : 20);
            end
         join
         rcount(20, 2, "gated count");
         rd(ad(3), rv, rs);
         check(rv & 32'h08, 0, 0, "go done cleared");
      end
      wreg(3, 8'h98);
      wreg(3, 8'h88);
      rchk(3, 32'h80, "single off clears go");
      end_sim();
   end
endmodule : gtc_timer_tb
bind gtc_timer gtc_timer_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire
